// file: core/crf_carry_adder.v
// Add-with-carry unit with optional inversion of the second operand
`timescale 1ns/100ps
`default_nettype none
`include "crf_defines.vh"

module crf_carry_adder
(
    input wire [`CRF_DW-1:0] x_i,
    input wire [`CRF_DW-1:0] y_i,
    input wire invert_y_i,
    input wire carry_i,
    output wire [`CRF_DW-1:0] sum_o,
    output wire carry_o,
    output wire overflow_o
);

    wire [`CRF_DW-1:0] y_eff;
    wire [`CRF_DW:0] wide_sum;

    // Subtraction is x plus not y; carry out then means no borrow
    assign y_eff = invert_y_i ? ~y_i : y_i;
    assign wide_sum = {1'b0, x_i} + {1'b0, y_eff} + {{`CRF_DW{1'b0}}, carry_i};
    assign sum_o = wide_sum[`CRF_DW-1:0];
    assign carry_o = wide_sum[`CRF_DW];
    // Signed overflow: like-signed operands giving a result of the other sign
    assign overflow_o = (x_i[`CRF_DW-1] == y_eff[`CRF_DW-1]) &&
                        (wide_sum[`CRF_DW-1] != x_i[`CRF_DW-1]);

endmodule // crf_carry_adder

`default_nettype wire

// file: core/crf_core_regs.v
// Core register file, program counter and condition flag logic of the processor
`timescale 1ns/100ps
`default_nettype none
`include "crf_defines.vh"

module crf_core_regs
(
    input wire SYS_CLK_I,
    input wire NRST_I,
    input wire [`CRF_AW-1:0] REG_ADDR_I,
    input wire [`CRF_DW-1:0] REG_WDATA_I,
    input wire REG_WR_I,
    input wire REG_RD_I,
    output reg [`CRF_DW-1:0] REG_RDATA_O,
    input wire [`CRF_IW-1:0] RD_A_IDX_I,
    input wire [`CRF_IW-1:0] RD_B_IDX_I,
    output reg [`CRF_DW-1:0] RD_A_DATA_O,
    output reg [`CRF_DW-1:0] RD_B_DATA_O,
    input wire WR_EN_I,
    input wire [`CRF_IW-1:0] WR_IDX_I,
    input wire [`CRF_DW-1:0] WR_DATA_I,
    output reg WR_REJECT_O,
    input wire ALU_EN_I,
    input wire [1:0] ALU_OP_I,
    input wire ALU_FLAG_SET_I,
    input wire [`CRF_DW-1:0] ALU_X_I,
    input wire [`CRF_DW-1:0] ALU_Y_I,
    output reg [`CRF_DW-1:0] ALU_RES_O,
    output wire [3:0] FLAGS_O,
    input wire PC_STEP_I,
    input wire [2:0] PC_STEP_SIZE_I,
    input wire BR_EN_I,
    input wire BR_INTERWORK_I,
    input wire BR_LINK_I,
    input wire [`CRF_DW-1:0] BR_TARGET_I,
    input wire EXC_ENTRY_I,
    input wire [`CRF_DW-1:0] EXC_LINK_I,
    input wire [`CRF_DW-1:0] EXC_VECTOR_I,
    output reg STATE_FAULT_O,
    input wire COPROC_REQ_I,
    output reg UNDEF_O,
    input wire FAULT_I,
    output reg FAULT_SYNC_O,
    input wire IRQ_I,
    output wire IRQ_PEND_O,
    input wire BUS_ERR_I,
    output wire IMPRECISE_O,
    input wire DEBUG_REQ_I,
    input wire DEBUG_EXIT_I,
    output wire DEBUG_STATE_O
);

    // Execution states
    localparam ST_RUN = 1'b0;
    localparam ST_DEBUG = 1'b1;

    reg state_q;
    reg state_d;
    reg [`CRF_DW-1:0] sp_q;
    reg [`CRF_DW-1:0] lr_q;
    reg [`CRF_DW-1:0] pc_q;
    reg [3:0] flags_q;
    reg ctrl_q;
    reg irq_s1_q;
    reg irq_s2_q;
    reg berr_s1_q;
    reg berr_s2_q;
    reg berr_seen_q;

    wire run;
    wire adder_inv;
    wire adder_cin;
    wire [`CRF_DW-1:0] adder_sum;
    wire adder_cout;
    wire adder_ovf;
    wire [`CRF_DW-1:0] gen_a;
    wire [`CRF_DW-1:0] gen_b;
    wire [`CRF_DW-1:0] gen_c;
    wire dp_wr;
    wire bus_wr_reg;
    wire gen_wr_en;
    wire [`CRF_IW-1:0] gen_wr_idx;
    wire [`CRF_DW-1:0] gen_wr_data;
    wire [`CRF_DW-1:0] pc_next_seq;
    wire [`CRF_DW-1:0] step_ext;
    wire br_take;
    wire bad_target;

    // Datapath register, flag and counter updates are frozen while halted in debug state
    assign run = (state_q == ST_RUN);

    // Next execution state; debug is the only departure from normal running
    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_RUN:
                if (DEBUG_REQ_I)
                    state_d = ST_DEBUG;
            ST_DEBUG:
                if (DEBUG_EXIT_I)
                    state_d = ST_RUN;
            default:
                state_d = ST_RUN;
        endcase
    end

    always @(posedge SYS_CLK_I)
    begin
        if (!NRST_I)
            state_q <= ST_RUN;
        else
            state_q <= state_d;
    end

    assign DEBUG_STATE_O = (state_q == ST_DEBUG);

    // Operand inversion and carry-in select the four adder flavours
    assign adder_inv = (ALU_OP_I == `CRF_OP_SUB) || (ALU_OP_I == `CRF_OP_SBC);
    assign adder_cin = (ALU_OP_I == `CRF_OP_SUB) ? 1'b1 :
                       (ALU_OP_I == `CRF_OP_ADD) ? 1'b0 :
                       flags_q[`CRF_BIT_C - 28];

    crf_carry_adder u_adder
    (
        .x_i(ALU_X_I),
        .y_i(ALU_Y_I),
        .invert_y_i(adder_inv),
        .carry_i(adder_cin),
        .sum_o(adder_sum),
        .carry_o(adder_cout),
        .overflow_o(adder_ovf)
    );

    // Registered adder result for the datapath
    always @(posedge SYS_CLK_I)
    begin
        if (!NRST_I)
            ALU_RES_O <= {`CRF_DW{1'b0}};
        else if (ALU_EN_I && run)
            ALU_RES_O <= adder_sum;
    end

    // Condition flags; a flag-setting operation wins over a software write
    always @(posedge SYS_CLK_I)
    begin
        if (!NRST_I)
            flags_q <= `CRF_FLAGS_RESET;
        else if (ALU_EN_I && ALU_FLAG_SET_I && run)
        begin
            flags_q[`CRF_BIT_N - 28] <= adder_sum[`CRF_DW-1];
            flags_q[`CRF_BIT_Z - 28] <= (adder_sum == {`CRF_DW{1'b0}});
            flags_q[`CRF_BIT_C - 28] <= adder_cout;
            flags_q[`CRF_BIT_V - 28] <= adder_ovf;
        end
        else if (REG_WR_I && (REG_ADDR_I == `CRF_OFS_FLAGS))
            flags_q <= REG_WDATA_I[`CRF_BIT_N:`CRF_BIT_V];
    end

    assign FLAGS_O = flags_q;

    // Datapath writes beat a software write to registers 0 to 14 in the same cycle
    assign dp_wr = WR_EN_I && run && (WR_IDX_I != `CRF_IDX_PC);
    assign bus_wr_reg = REG_WR_I && (REG_ADDR_I <= `CRF_OFS_LR);
    assign gen_wr_en = dp_wr || bus_wr_reg;
    assign gen_wr_idx = dp_wr ? WR_IDX_I : REG_ADDR_I[`CRF_IW-1:0];
    assign gen_wr_data = dp_wr ? WR_DATA_I : REG_WDATA_I;

    crf_gpr_bank u_bank
    (
        .clk_i(SYS_CLK_I),
        .nrst_i(NRST_I),
        .wr_en_i(gen_wr_en && (gen_wr_idx < `CRF_IDX_SP)),
        .wr_idx_i(gen_wr_idx),
        .wr_data_i(gen_wr_data),
        .rd_a_idx_i(RD_A_IDX_I),
        .rd_b_idx_i(RD_B_IDX_I),
        .rd_c_idx_i(REG_ADDR_I[`CRF_IW-1:0]),
        .rd_a_o(gen_a),
        .rd_b_o(gen_b),
        .rd_c_o(gen_c)
    );

    // Stack pointer starts at the top of the main stack
    always @(posedge SYS_CLK_I)
    begin
        if (!NRST_I)
            sp_q <= `CRF_SP_RESET;
        else if (gen_wr_en && (gen_wr_idx == `CRF_IDX_SP))
            sp_q <= gen_wr_data;
    end

    // Link register: exception entry, then branch-with-link, then plain writes
    always @(posedge SYS_CLK_I)
    begin
        if (!NRST_I)
            lr_q <= `CRF_GEN_RESET;
        else if (EXC_ENTRY_I && run)
            lr_q <= EXC_LINK_I;
        else if (br_take && BR_LINK_I)
            lr_q <= pc_next_seq | 32'h00000001;
        else if (gen_wr_en && (gen_wr_idx == `CRF_IDX_LR))
            lr_q <= gen_wr_data;
    end

    // Return link is the address after the current instruction
    assign step_ext = {{(`CRF_DW-3){1'b0}}, PC_STEP_SIZE_I};
    assign pc_next_seq = pc_q + step_ext;
    assign br_take = BR_EN_I && run;

    // An interworking target must keep the single state, so bit 0 has to be set
    assign bad_target = br_take && BR_INTERWORK_I && !BR_TARGET_I[0];

    // Program counter; bit 0 is cleared on exception and branch loads, but a step adds the step size unchanged
    always @(posedge SYS_CLK_I)
    begin
        if (!NRST_I)
            pc_q <= `CRF_PC_RESET;
        else if (EXC_ENTRY_I && run)
            pc_q <= {EXC_VECTOR_I[`CRF_DW-1:1], 1'b0};
        else if (br_take)
            pc_q <= {BR_TARGET_I[`CRF_DW-1:1], 1'b0};
        else if (PC_STEP_I && run)
            pc_q <= pc_next_seq;
    end

    // Invalid interworking target is flagged for the fault logic, one cycle
    always @(posedge SYS_CLK_I)
    begin
        if (!NRST_I)
            STATE_FAULT_O <= 1'b0;
        else
            STATE_FAULT_O <= bad_target;
    end

    // Index 15 may be read but a write there is refused and reported
    always @(posedge SYS_CLK_I)
    begin
        if (!NRST_I)
            WR_REJECT_O <= 1'b0;
        else
            WR_REJECT_O <= WR_EN_I && run && (WR_IDX_I == `CRF_IDX_PC);
    end

    // There is no coprocessor, so every such request is undefined
    always @(posedge SYS_CLK_I)
    begin
        if (!NRST_I)
            UNDEF_O <= 1'b0;
        else
            UNDEF_O <= COPROC_REQ_I;
    end

    // Faults come from logic on this clock and stay tied to their instruction
    always @(posedge SYS_CLK_I)
    begin
        if (!NRST_I)
            FAULT_SYNC_O <= 1'b0;
        else
            FAULT_SYNC_O <= FAULT_I;
    end

    // Interrupt and bus error pins arrive unsynchronised; two flops each
    always @(posedge SYS_CLK_I)
    begin
        if (!NRST_I)
        begin
            irq_s1_q <= 1'b0;
            irq_s2_q <= 1'b0;
            berr_s1_q <= 1'b0;
            berr_s2_q <= 1'b0;
        end
        else
        begin
            irq_s1_q <= IRQ_I;
            irq_s2_q <= irq_s1_q;
            berr_s1_q <= BUS_ERR_I;
            berr_s2_q <= berr_s1_q;
        end
    end

    assign IRQ_PEND_O = irq_s2_q && !ctrl_q;

    // Imprecise error is sticky until software clears it; a new error wins
    always @(posedge SYS_CLK_I)
    begin
        if (!NRST_I)
            berr_seen_q <= 1'b0;
        else if (berr_s2_q)
            berr_seen_q <= 1'b1;
        else if (REG_WR_I && (REG_ADDR_I == `CRF_OFS_STATUS) && REG_WDATA_I[2])
            berr_seen_q <= 1'b0;
    end

    assign IMPRECISE_O = berr_seen_q;

    // Control word: bit 0 masks the interrupt pending output
    always @(posedge SYS_CLK_I)
    begin
        if (!NRST_I)
            ctrl_q <= `CRF_CTRL_RESET;
        else if (REG_WR_I && (REG_ADDR_I == `CRF_OFS_CTRL))
            ctrl_q <= REG_WDATA_I[0];
    end

    // Datapath read ports, one cycle latency; index 15 reads the counter
    always @(posedge SYS_CLK_I)
    begin
        if (!NRST_I)
        begin
            RD_A_DATA_O <= {`CRF_DW{1'b0}};
            RD_B_DATA_O <= {`CRF_DW{1'b0}};
        end
        else
        begin
            RD_A_DATA_O <= (RD_A_IDX_I == `CRF_IDX_SP) ? sp_q :
                           (RD_A_IDX_I == `CRF_IDX_LR) ? lr_q :
                           (RD_A_IDX_I == `CRF_IDX_PC) ? pc_q : gen_a;
            RD_B_DATA_O <= (RD_B_IDX_I == `CRF_IDX_SP) ? sp_q :
                           (RD_B_IDX_I == `CRF_IDX_LR) ? lr_q :
                           (RD_B_IDX_I == `CRF_IDX_PC) ? pc_q : gen_b;
        end
    end

    // Software read port; reserved bits and unmapped words read as zero
    always @(posedge SYS_CLK_I)
    begin
        if (!NRST_I)
            REG_RDATA_O <= {`CRF_DW{1'b0}};
        else if (REG_RD_I)
        begin
            case (REG_ADDR_I)
                `CRF_OFS_SP:
                    REG_RDATA_O <= sp_q;
                `CRF_OFS_LR:
                    REG_RDATA_O <= lr_q;
                `CRF_OFS_PC:
                    REG_RDATA_O <= pc_q;
                `CRF_OFS_FLAGS:
                    REG_RDATA_O <= {flags_q, 28'h0000000};
                `CRF_OFS_STATUS:
                    REG_RDATA_O <= {29'h00000000, berr_seen_q, irq_s2_q, state_q};
                `CRF_OFS_CTRL:
                    REG_RDATA_O <= {31'h00000000, ctrl_q};
                default:
                    REG_RDATA_O <= (REG_ADDR_I <= `CRF_OFS_GEN_LAST) ? gen_c : {`CRF_DW{1'b0}};
            endcase
        end
        else
            REG_RDATA_O <= {`CRF_DW{1'b0}};
    end

endmodule // crf_core_regs

`default_nettype wire

// file: core/crf_gpr_bank.v
// Bank of thirteen general-purpose 32-bit registers, one write and three read ports
`timescale 1ns/100ps
`default_nettype none
`include "crf_defines.vh"

module crf_gpr_bank
(
    input wire clk_i,
    input wire nrst_i,
    input wire wr_en_i,
    input wire [`CRF_IW-1:0] wr_idx_i,
    input wire [`CRF_DW-1:0] wr_data_i,
    input wire [`CRF_IW-1:0] rd_a_idx_i,
    input wire [`CRF_IW-1:0] rd_b_idx_i,
    input wire [`CRF_IW-1:0] rd_c_idx_i,
    output wire [`CRF_DW-1:0] rd_a_o,
    output wire [`CRF_DW-1:0] rd_b_o,
    output wire [`CRF_DW-1:0] rd_c_o
);

    wire [`CRF_DW-1:0] gen_q [0:`CRF_NGEN-1];

    // One register per entry; only indices below thirteen ever match
    genvar gi;
    generate
        for (gi = 0; gi < `CRF_NGEN; gi = gi + 1)
        begin : g_ent
            reg [`CRF_DW-1:0] val_q;
            always @(posedge clk_i)
            begin
                if (!nrst_i)
                    val_q <= `CRF_GEN_RESET;
                else if (wr_en_i && ({{(32-`CRF_IW){1'b0}}, wr_idx_i} == gi))
                    val_q <= wr_data_i;
            end
            assign gen_q[gi] = val_q;
        end
    endgenerate

    // Out-of-range indices read zero; the stack index is the first special one, selected by the top
    assign rd_a_o = (rd_a_idx_i < `CRF_IDX_SP) ? gen_q[rd_a_idx_i] : {`CRF_DW{1'b0}};
    assign rd_b_o = (rd_b_idx_i < `CRF_IDX_SP) ? gen_q[rd_b_idx_i] : {`CRF_DW{1'b0}};
    assign rd_c_o = (rd_c_idx_i < `CRF_IDX_SP) ? gen_q[rd_c_idx_i] : {`CRF_DW{1'b0}};

endmodule // crf_gpr_bank

`default_nettype wire

// file: pkg/crf_defines.vh
// Constants shared by the core register and status flag design
`ifndef CRF_DEFINES_VH
`define CRF_DEFINES_VH

// Word, address and index widths, and the general register count
`define CRF_DW 32
`define CRF_AW 5
`define CRF_IW 4
`define CRF_NGEN 13

// Register indices on the datapath ports
`define CRF_IDX_SP 4'hD
`define CRF_IDX_LR 4'hE
`define CRF_IDX_PC 4'hF

// Software register map, word addresses on the plain port
`define CRF_OFS_GEN_LAST 5'h0C
`define CRF_OFS_SP 5'h0D
`define CRF_OFS_LR 5'h0E
`define CRF_OFS_PC 5'h0F
`define CRF_OFS_FLAGS 5'h10
`define CRF_OFS_STATUS 5'h11
`define CRF_OFS_CTRL 5'h12

// Reset values
`define CRF_SP_RESET 32'h20001000
`define CRF_PC_RESET 32'h00000100
`define CRF_GEN_RESET 32'h00000000
`define CRF_FLAGS_RESET 4'h0
`define CRF_CTRL_RESET 1'h0

// Condition flag positions in the status flag word
`define CRF_BIT_N 31
`define CRF_BIT_Z 30
`define CRF_BIT_C 29
`define CRF_BIT_V 28

// Adder operation codes
`define CRF_OP_ADD 2'h0
`define CRF_OP_ADC 2'h1
`define CRF_OP_SUB 2'h2
`define CRF_OP_SBC 2'h3

`endif

// file: verif/crf_core_regs_chk.sv
// Port assertions for the core register and status flag block
`timescale 1ns/100ps
`default_nettype none
`include "crf_defines.vh"

module crf_core_regs_chk
(
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    input wire logic [31:0] ALU_X_I,
    input wire logic [31:0] ALU_Y_I,
    input wire logic [1:0] ALU_OP_I,
    input wire logic ALU_EN_I,
    input wire logic ALU_FLAG_SET_I,
    input wire logic [31:0] ALU_RES_O,
    input wire logic [3:0] FLAGS_O,
    input wire logic REG_WR_I,
    input wire logic [4:0] REG_ADDR_I,
    input wire logic WR_EN_I,
    input wire logic [3:0] WR_IDX_I,
    input wire logic WR_REJECT_O,
    input wire logic COPROC_REQ_I,
    input wire logic UNDEF_O,
    input wire logic DEBUG_STATE_O
);
    default clocking @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!NRST_I);
    // Operations are dropped in debug state, so both qualifiers exclude it
    wire op_go = ALU_EN_I && !DEBUG_STATE_O;
    wire fs_go = op_go && ALU_FLAG_SET_I;
    AST_SUB_RES: assert property (
        op_go && ALU_OP_I == `CRF_OP_SUB |=> ALU_RES_O == $past(ALU_X_I) - $past(ALU_Y_I))
        else $error("subtract result wrong");
    AST_SUB_CARRY: assert property (
        fs_go && ALU_OP_I == `CRF_OP_SUB |=> FLAGS_O[1] == ($past(ALU_X_I) >= $past(ALU_Y_I)))
        else $error("carry after subtract wrong");
    AST_SBC_BORROW: assert property (
        fs_go && ALU_OP_I == `CRF_OP_SBC && !FLAGS_O[1] |=> FLAGS_O[1] == ($past(ALU_X_I) > $past(ALU_Y_I))
        && ALU_RES_O == $past(ALU_X_I) - $past(ALU_Y_I) - 32'h1) else $error("borrowing subtract wrong");
    AST_ADD_CARRY: assert property (
        fs_go && ALU_OP_I == `CRF_OP_ADD |=> FLAGS_O[1] == ({1'b0, $past(ALU_X_I)} + {1'b0, $past(ALU_Y_I)} > 33'h0FFFFFFFF))
        else $error("carry after add wrong");
    AST_SUB_OVF: assert property (
        fs_go && ALU_OP_I == `CRF_OP_SUB |=> FLAGS_O[0] == ($past(ALU_X_I[31]) != $past(ALU_Y_I[31])
        && ALU_RES_O[31] != $past(ALU_X_I[31]))) else $error("overflow after subtract wrong");
    AST_NEG: assert property (fs_go |=> FLAGS_O[3] == ALU_RES_O[31])
        else $error("negative flag wrong");
    AST_ZERO: assert property (fs_go |=> FLAGS_O[2] == (ALU_RES_O == 32'h0))
        else $error("zero flag wrong");
    AST_HOLD: assert property (
        !fs_go && !(REG_WR_I && REG_ADDR_I == `CRF_OFS_FLAGS) |=> $stable(FLAGS_O))
        else $error("flags moved without cause");
    AST_REJECT: assert property (WR_REJECT_O |-> $past(WR_EN_I) && $past(WR_IDX_I) == `CRF_IDX_PC)
        else $error("reject without counter write");
    AST_UNDEF: assert property (COPROC_REQ_I && !DEBUG_STATE_O |=> UNDEF_O)
        else $error("coprocessor request not refused");
endmodule // crf_core_regs_chk

bind crf_core_regs crf_core_regs_chk u_chk (.SYS_CLK_I(SYS_CLK_I), .NRST_I(NRST_I), .ALU_X_I(ALU_X_I),
    .ALU_Y_I(ALU_Y_I), .ALU_OP_I(ALU_OP_I), .ALU_EN_I(ALU_EN_I), .ALU_FLAG_SET_I(ALU_FLAG_SET_I),
    .ALU_RES_O(ALU_RES_O), .FLAGS_O(FLAGS_O), .REG_WR_I(REG_WR_I), .REG_ADDR_I(REG_ADDR_I), .WR_EN_I(WR_EN_I),
    .WR_IDX_I(WR_IDX_I), .WR_REJECT_O(WR_REJECT_O), .COPROC_REQ_I(COPROC_REQ_I), .UNDEF_O(UNDEF_O),
    .DEBUG_STATE_O(DEBUG_STATE_O));

`default_nettype wire

// file: verif/crf_core_regs_tb.sv
// Self-checking testbench for the core register and status flag block
`timescale 1ns/100ps
`default_nettype none
`include "crf_defines.vh"

module crf_core_regs_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [31:0] wdata = 32'h0, wr_data = 32'h0, alu_x = 32'h0, alu_y = 32'h0;
    logic [31:0] br_tgt = 32'h0, exc_lnk = 32'h0, exc_vec = 32'h0;
    logic wr = 1'b0, rd = 1'b0, wr_en = 1'b0, alu_en = 1'b0, alu_fs = 1'b0, step = 1'b0, br = 1'b0, br_iw = 1'b0;
    logic br_lk = 1'b0, exc = 1'b0, cop = 1'b0, flt = 1'b0, irq = 1'b0, berr = 1'b0, dbg_req = 1'b0, dbg_exit = 1'b0;
    logic [3:0] rda_idx = 4'h0, rdb_idx = 4'h0, wr_idx = 4'h0, ef = 4'h0;
    logic [1:0] alu_op = 2'h0;
    logic [2:0] step_sz = 3'h0;
    wire [31:0] rdata, rda, rdb, alu_res;
    wire [3:0] flags;
    wire wr_rej, st_flt, undef, flt_sync, irq_pend, impr, dbg_st;
    int failures = 0;
    int check_count = 0;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    crf_core_regs DUT
    (
        .SYS_CLK_I(clk), .NRST_I(nrst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdata), .RD_A_IDX_I(rda_idx), .RD_B_IDX_I(rdb_idx), .RD_A_DATA_O(rda), .RD_B_DATA_O(rdb),
        .WR_EN_I(wr_en), .WR_IDX_I(wr_idx), .WR_DATA_I(wr_data), .WR_REJECT_O(wr_rej), .ALU_EN_I(alu_en),
        .ALU_OP_I(alu_op), .ALU_FLAG_SET_I(alu_fs), .ALU_X_I(alu_x), .ALU_Y_I(alu_y), .ALU_RES_O(alu_res),
        .FLAGS_O(flags), .PC_STEP_I(step), .PC_STEP_SIZE_I(step_sz), .BR_EN_I(br), .BR_INTERWORK_I(br_iw),
        .BR_LINK_I(br_lk), .BR_TARGET_I(br_tgt), .EXC_ENTRY_I(exc), .EXC_LINK_I(exc_lnk), .EXC_VECTOR_I(exc_vec),
        .STATE_FAULT_O(st_flt), .COPROC_REQ_I(cop), .UNDEF_O(undef), .FAULT_I(flt), .FAULT_SYNC_O(flt_sync),
        .IRQ_I(irq), .IRQ_PEND_O(irq_pend), .BUS_ERR_I(berr), .IMPRECISE_O(impr), .DEBUG_REQ_I(dbg_req),
        .DEBUG_EXIT_I(dbg_exit), .DEBUG_STATE_O(dbg_st)
    );

    task automatic finish_test();
        if (failures == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Case equality so an unknown never passes
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic bus_rd(input logic [4:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask

    task automatic dp_wr(input logic [3:0] i, input logic [31:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_idx <= i;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // Expected sum and flags kept here, carry chained through ef
    task automatic alu(input logic [1:0] op, input logic [31:0] x, input logic [31:0] y, input logic fs);
        logic [32:0] s;
        logic [31:0] yy;
        yy = op[1] ? ~y : y;
        s = {1'b0, x} + {1'b0, yy} + (op[0] ? ef[1] : op[1]);
        if (fs)
            ef = {s[31], (s[31:0] == 32'h0), s[32], (x[31] == yy[31] && s[31] != x[31])};
        @(posedge clk);
        alu_en <= 1'b1;
        alu_op <= op;
        alu_x <= x;
        alu_y <= y;
        alu_fs <= fs;
        @(posedge clk);
        alu_en <= 1'b0;
        #1 chk(alu_res, s[31:0]);
        chk({28'h0, flags}, {28'h0, ef});
    endtask

    task automatic br_go(input logic iw, input logic lk, input logic [31:0] t, input logic f);
        @(posedge clk);
        br <= 1'b1;
        br_iw <= iw;
        br_lk <= lk;
        br_tgt <= t;
        step <= lk;
        step_sz <= 3'h2;
        @(posedge clk);
        br <= 1'b0;
        br_lk <= 1'b0;
        step <= 1'b0;
        #1 chk({31'h0, st_flt}, {31'h0, f});
        bus_rd(`CRF_OFS_PC, {t[31:1], 1'b0});
    endtask

    task automatic t_reset();
        bus_rd(`CRF_OFS_SP, `CRF_SP_RESET);
        bus_rd(`CRF_OFS_PC, `CRF_PC_RESET);
        bus_rd(`CRF_OFS_LR, 32'h0);
        bus_rd(5'h00, 32'h0);
        bus_rd(`CRF_OFS_FLAGS, 32'h0);
    endtask

    task automatic t_alu();
        alu(`CRF_OP_SUB, 32'h5, 32'h5, 1'b1);
        alu(`CRF_OP_SUB, 32'h5, 32'h6, 1'b1);
        alu(`CRF_OP_SBC, 32'h5, 32'h5, 1'b1);
        alu(`CRF_OP_SBC, 32'h6, 32'h5, 1'b1);
        alu(`CRF_OP_SUB, 32'h80000000, 32'h1, 1'b1);
        alu(`CRF_OP_ADD, 32'hFFFFFFFF, 32'h1, 1'b1);
        alu(`CRF_OP_ADC, 32'h1, 32'h1, 1'b1);
        alu(`CRF_OP_ADD, 32'h7FFFFFFF, 32'h1, 1'b1);
        alu(`CRF_OP_SUB, 32'h3, 32'h3, 1'b0);
        bus_wr(`CRF_OFS_FLAGS, 32'h5FFFFFFF);
        ef = 4'h5;
        bus_rd(`CRF_OFS_FLAGS, 32'h50000000);
        chk({28'h0, flags}, 32'h5);
    endtask

    task automatic t_regs();
        for (int i = 0; i < 15; i++)
            dp_wr(i[3:0], 32'hC0DE0000 + i[3:0]);
        for (int i = 0; i < 15; i++)
        begin
            bus_rd(i[4:0], 32'hC0DE0000 + i[3:0]);
            @(posedge clk);
            rda_idx <= i[3:0];
            rdb_idx <= 4'hE - i[3:0];
            @(posedge clk);
            #1 chk(rda, 32'hC0DE0000 + i[3:0]);
            chk(rdb, 32'hC0DE0000 + 4'(4'hE - i[3:0]));
        end
        dp_wr(`CRF_IDX_PC, 32'h0000DEAD);
        #1 chk({31'h0, wr_rej}, 32'h1);
        bus_wr(`CRF_OFS_PC, 32'h0000BEEF);
        bus_rd(`CRF_OFS_PC, `CRF_PC_RESET);
        bus_rd(5'h13, 32'h0);
    endtask

    // Link value is the stepped counter with bit 0 set
    task automatic t_branch();
        br_go(1'b0, 1'b1, 32'h201, 1'b0);
        bus_rd(`CRF_OFS_LR, 32'h103);
        br_go(1'b1, 1'b0, 32'h300, 1'b1);
        br_go(1'b1, 1'b0, 32'h401, 1'b0);
        @(posedge clk);
        exc <= 1'b1;
        exc_lnk <= 32'hFFFFFFF9;
        exc_vec <= 32'h501;
        @(posedge clk);
        exc <= 1'b0;
        bus_rd(`CRF_OFS_PC, 32'h500);
        bus_rd(`CRF_OFS_LR, 32'hFFFFFFF9);
        // Plain step with no branch beside it; size two is still set from the branches
        @(posedge clk);
        step <= 1'b1;
        @(posedge clk);
        step <= 1'b0;
        bus_rd(`CRF_OFS_PC, 32'h502);
    endtask

    task automatic t_misc();
        @(posedge clk);
        cop <= 1'b1;
        flt <= 1'b1;
        @(posedge clk);
        cop <= 1'b0;
        flt <= 1'b0;
        #1 chk({30'h0, undef, flt_sync}, 32'h3);
        @(posedge clk);
        irq <= 1'b1;
        berr <= 1'b1;
        @(posedge clk);
        berr <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk({30'h0, irq_pend, impr}, 32'h3);
        bus_rd(`CRF_OFS_STATUS, 32'h6);
        bus_wr(`CRF_OFS_STATUS, 32'h4);
        bus_wr(`CRF_OFS_CTRL, 32'h1);
        @(posedge clk);
        irq <= 1'b0;
        #1 chk({30'h0, irq_pend, impr}, 32'h0);
    endtask

    // Datapath writes are dropped while in debug state
    task automatic t_debug();
        @(posedge clk);
        dbg_req <= 1'b1;
        @(posedge clk);
        dbg_req <= 1'b0;
        #1 chk({31'h0, dbg_st}, 32'h1);
        dp_wr(4'h2, 32'h12345678);
        bus_rd(5'h02, 32'hC0DE0002);
        // A flag-setting operation while halted must leave result and flags alone
        @(posedge clk);
        alu_en <= 1'b1;
        alu_fs <= 1'b1;
        alu_op <= `CRF_OP_SUB;
        alu_x <= 32'h2;
        alu_y <= 32'h1;
        @(posedge clk);
        alu_en <= 1'b0;
        alu_fs <= 1'b0;
        #1 chk({alu_res[27:0], flags}, 32'h5);
        @(posedge clk);
        dbg_exit <= 1'b1;
        @(posedge clk);
        dbg_exit <= 1'b0;
        #1 chk({31'h0, dbg_st}, 32'h0);
    endtask

    // Main sequence after six cycles of reset
    initial
    begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_alu();
        t_regs();
        t_branch();
        t_misc();
        t_debug();
        finish_test();
    end

    // Hang guard
    initial
    begin
        repeat (5000) @(posedge clk);
        failures++;
        finish_test();
    end
endmodule // crf_core_regs_tb

`default_nettype wire
